// [rofd_defs.vh]
`ifndef ROFD_DEFS_VH
`define ROFD_DEFS_VH
// register offsets (byte addresses)
`define ROFD_REG_CTRL 8'h00
`define ROFD_REG_FSEL 8'h04
`define ROFD_REG_FPOS 8'h08
`define ROFD_REG_DSEL 8'h0c
`define ROFD_REG_STAT 8'h10
`define ROFD_REG_OUT 8'h14
// control register fields
`define ROFD_CTRL_DIS_EN 0
`define ROFD_CTRL_FORCE_GO 1
`define ROFD_CTRL_FORCE_PERM 2
`define ROFD_CTRL_FORCE_GRP 3
`define ROFD_CTRL_DIS_GO 4
`define ROFD_CTRL_DIS_PERM 5
`define ROFD_CTRL_FORCE_STOP 6
`define ROFD_CTRL_DIS_STOP 7
`define ROFD_CTRL_GSEL_LSB 8
// reset values
`define ROFD_CTRL_RST 32'h00000000
// timeout in milliseconds and cycles at 10 MHz
`define ROFD_TIMEOUT_MS 1000
`define ROFD_CLK_KHZ 10000
`define ROFD_TIMEOUT_CYC (`ROFD_TIMEOUT_MS * `ROFD_CLK_KHZ)
`endif

// [rofd_relay_override.v]
// Notes on behaviour
// - timed force holds forced position only until its timeout expires
// - permanent force holds until explicitly withdrawn
// - single or group force; group force overrides single force
// - disarmed contact ignores all force commands
// - force applies only if not disarmed and command applied
// - disarm inhibits switching of contacts in the selected group except NODIS_MASK, latched or hold-timer contacts
// - zone interlock and supervision contacts never disarm
// - disarm permanent or timed; timed ends on timeout expiry
// - latched contact cannot be disarmed until latch cleared
// - contact with running hold timer cannot be disarmed
// - disarm only while disarm control enable is active
// - disarm only once the direct command applied
`timescale 1ns/1ps
`include "rofd_defs.vh"
`default_nettype none
module rofd_relay_override #(
   parameter NGRP = 2,
   parameter GW = 4,
   parameter [31:0] TIMEOUT_CYC = `ROFD_TIMEOUT_CYC,
   parameter [NGRP*GW-1:0] NODIS_MASK = 8'h00
)(
   // clock, reset, enable
   input wire i_clk,
   input wire i_rst,
   input wire i_ce,
   // wishbone slave
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [7:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   // protection logic side
   input wire [NGRP*GW-1:0] i_logic_out,
   input wire [NGRP*GW-1:0] i_latched,
   input wire [NGRP*GW-1:0] i_hold_run,
   // relay contacts
   output reg [NGRP*GW-1:0] o_contact
);
   localparam N = NGRP*GW;

   // ******************************************************************
   // registers
   // ******************************************************************
   reg [31:0] ctrl;
   reg [N-1:0] fsel;
   reg [N-1:0] fpos;
   reg [NGRP-1:0] dsel;
   reg [N-1:0] sgl_act;
   reg [N-1:0] sgl_pos;
   reg [31:0] sgl_tmr;
   reg sgl_perm;
   reg [NGRP-1:0] grp_act;
   reg [N-1:0] grp_pos;
   reg [31:0] grp_tmr;
   reg grp_perm;
   reg [NGRP-1:0] dis_req;
   reg [31:0] dis_tmr;
   reg dis_perm;
   reg [N-1:0] disarmed;
   reg [N-1:0] next_contact;
   reg [N-1:0] next_disarmed;
   reg [NGRP-1:0] gsel;
   integer i;

   wire wr = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack & i_wb_sel[0];
   wire rd_any = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   wire wr_ctrl = wr & (i_wb_adr == `ROFD_REG_CTRL);
   wire f_go = wr_ctrl & i_wb_dat[`ROFD_CTRL_FORCE_GO];
   wire f_grp = i_wb_dat[`ROFD_CTRL_FORCE_GRP];
   wire f_perm = i_wb_dat[`ROFD_CTRL_FORCE_PERM];
   wire f_stop = wr_ctrl & i_wb_dat[`ROFD_CTRL_FORCE_STOP];
   wire d_go = wr_ctrl & i_wb_dat[`ROFD_CTRL_DIS_GO];
   wire d_stop = wr_ctrl & i_wb_dat[`ROFD_CTRL_DIS_STOP];
   wire sgl_exp = ~sgl_perm & (sgl_tmr == 32'h00000001);
   wire grp_exp = ~grp_perm & (grp_tmr == 32'h00000001);
   wire dis_exp = ~dis_perm & (dis_tmr == 32'h00000001);

   always @*
   begin
      gsel = i_wb_dat[`ROFD_CTRL_GSEL_LSB +: NGRP];
   end

   // ******************************************************************
   // bus slave and override state
   // ******************************************************************
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
         ctrl <= `ROFD_CTRL_RST;
         fsel <= {N{1'b0}};
         fpos <= {N{1'b0}};
         dsel <= {NGRP{1'b0}};
         sgl_act <= {N{1'b0}};
         sgl_pos <= {N{1'b0}};
         sgl_tmr <= 32'h00000000;
         sgl_perm <= 1'b0;
         grp_act <= {NGRP{1'b0}};
         grp_pos <= {N{1'b0}};
         grp_tmr <= 32'h00000000;
         grp_perm <= 1'b0;
         dis_req <= {NGRP{1'b0}};
         dis_tmr <= 32'h00000000;
         dis_perm <= 1'b0;
      end
      else if (i_ce)
      begin
         o_wb_ack <= rd_any;
         o_wb_dat <= 32'h00000000;
         if (rd_any & ~i_wb_we)
         begin
            case (i_wb_adr)
               `ROFD_REG_CTRL: o_wb_dat <= ctrl;
               `ROFD_REG_FSEL: o_wb_dat[N-1:0] <= fsel;
               `ROFD_REG_FPOS: o_wb_dat[N-1:0] <= fpos;
               `ROFD_REG_DSEL: o_wb_dat[NGRP-1:0] <= dsel;
               `ROFD_REG_STAT: o_wb_dat[N-1:0] <= disarmed;
               `ROFD_REG_OUT: o_wb_dat[N-1:0] <= o_contact;
               default: o_wb_dat <= 32'h00000000;
            endcase
         end
         if (wr_ctrl)
            ctrl <= {24'h000000, i_wb_dat[7:0] & 8'h21} |
                    {{(24-NGRP){1'b0}}, gsel, 8'h00};
         if (wr & (i_wb_adr == `ROFD_REG_FSEL))
            fsel <= i_wb_dat[N-1:0];
         if (wr & (i_wb_adr == `ROFD_REG_FPOS))
            fpos <= i_wb_dat[N-1:0];
         if (wr & (i_wb_adr == `ROFD_REG_DSEL))
            dsel <= i_wb_dat[NGRP-1:0];
         // single force
         if (sgl_tmr != 32'h00000000)
            sgl_tmr <= sgl_tmr - 32'h00000001;
         if (f_go & ~f_grp)
         begin
            sgl_act <= fsel;
            sgl_pos <= fpos;
            sgl_perm <= f_perm;
            sgl_tmr <= TIMEOUT_CYC;
         end
         else if ((f_stop & ~f_grp) | sgl_exp)
            sgl_act <= {N{1'b0}};
         // group force
         if (grp_tmr != 32'h00000000)
            grp_tmr <= grp_tmr - 32'h00000001;
         if (f_go & f_grp)
         begin
            grp_act <= gsel;
            grp_pos <= fpos;
            grp_perm <= f_perm;
            grp_tmr <= TIMEOUT_CYC;
         end
         else if ((f_stop & f_grp) | grp_exp)
            grp_act <= {NGRP{1'b0}};
         // disarm request
         if (dis_tmr != 32'h00000000)
            dis_tmr <= dis_tmr - 32'h00000001;
         if (d_go)
         begin
            dis_req <= dsel;
            dis_perm <= i_wb_dat[`ROFD_CTRL_DIS_PERM];
            dis_tmr <= TIMEOUT_CYC;
         end
         else if (d_stop | dis_exp)
            dis_req <= {NGRP{1'b0}};
      end
   end

   // ******************************************************************
   // output selection
   // ******************************************************************
   always @*
   begin
      next_contact = i_logic_out;
      next_disarmed = disarmed;
      for (i = 0; i < N; i = i + 1)
      begin
         if (dis_req[i/GW] & ctrl[`ROFD_CTRL_DIS_EN]
             & ~NODIS_MASK[i])
         begin
            if (~i_latched[i] & ~i_hold_run[i])
               next_disarmed[i] = 1'b1;
         end
         else
            next_disarmed[i] = 1'b0;
         if (next_disarmed[i])
            next_contact[i] = o_contact[i];
         else if (grp_act[i/GW])
            next_contact[i] = grp_pos[i];
         else if (sgl_act[i])
            next_contact[i] = sgl_pos[i];
      end
   end

   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_contact <= {N{1'b0}};
         disarmed <= {N{1'b0}};
      end
      else if (i_ce)
      begin
         o_contact <= next_contact;
         disarmed <= next_disarmed;
      end
   end
endmodule
`default_nettype wire

// [rofd_checker_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module rofd_checker #(parameter NGRP = 2, parameter GW = 4)(
   // clock, reset, enable
   input wire i_clk, i_rst, i_ce,
   // wishbone
   input wire i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack,
   input wire [7:0] i_wb_adr,
   input wire [31:0] o_wb_dat,
   // contacts
   input wire [NGRP*GW-1:0] i_logic_out, o_contact
);
   reg wr_seen;
   always @(posedge i_clk)
      wr_seen <= i_rst ? 1'b0 : wr_seen | (i_wb_cyc & i_wb_we);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack too long");
   a_ack_answer: assert property
      (i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("no ack");
   a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
      else $error("stray ack");
   a_rst_clear: assert property (disable iff (1'b0)
      i_rst |=> !o_contact && !o_wb_ack) else $error("reset");
   a_unmap_zero: assert property
      (o_wb_ack && !i_wb_we && i_wb_adr == 8'h18 |-> o_wb_dat == 0)
      else $error("unmapped read");
   a_stat_idle: assert property (
      o_wb_ack && !wr_seen && i_wb_adr == 8'h10 |-> o_wb_dat == 0)
      else $error("disarmed unasked");
   a_ce_freeze: assert property (!i_ce |=> $stable(o_contact))
      else $error("moved without enable");
   a_idle_follow: assert property (
      !wr_seen && $past(i_ce) && !$past(i_rst)
      |-> o_contact == $past(i_logic_out)) else $error("not following");
   cover property (o_wb_ack && i_wb_we);
   cover property ($changed(o_contact));
   cover property (!i_ce);
endmodule
bind rofd_relay_override rofd_checker #(.NGRP(NGRP), .GW(GW)) u_chk (
   .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .o_wb_ack(o_wb_ack),
   .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .i_logic_out(i_logic_out),
   .o_contact(o_contact));
`default_nettype wire

// [rofd_prot_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rofd_prot_model (
   input wire i_clk,
   input wire [23:0] i_req,
   output logic [7:0] o_logic_out, o_latched, o_hold_run
);
   // protection logic only changes on clock edges
   always_ff @(posedge i_clk)
      {o_hold_run, o_latched, o_logic_out} <= i_req;
endmodule
`default_nettype wire

// [relay_output_force_disarm_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module relay_output_force_disarm_tb_top;
   logic i_clk = 0, i_rst = 1, i_ce = 1, cyc = 0, stb = 0, we = 0, ack;
   logic [7:0] adr = 0, lo = 0, la = 0, ho = 0, lgo, lat, hld, o_contact;
   logic [31:0] dat = 0, rd, o_wb_dat;
   logic [3:0] sel = 4'hf;
   int n_fail = 0, comparisons = 0;
   initial forever #50 i_clk = ~i_clk;
   rofd_prot_model u_prot (.i_clk(i_clk), .i_req({ho, la, lo}),
      .o_logic_out(lgo), .o_latched(lat), .o_hold_run(hld));
   rofd_relay_override #(.TIMEOUT_CYC(32'd20), .NODIS_MASK(8'h80)) dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(dat), .o_wb_dat(o_wb_dat), .o_wb_ack(ack),
      .i_logic_out(lgo), .i_latched(lat), .i_hold_run(hld),
      .o_contact(o_contact));
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge i_clk); while (ack !== 1'b1);
      rd = o_wb_dat;
      cyc <= 0;
      stb <= 0;
      @(posedge i_clk);
   endtask
   task chk(input logic [31:0] g, e);
      comparisons++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      wb(0, a, 0);
      chk(rd, e);
   endtask
   task cc(input logic [7:0] e);
      repeat (3) @(posedge i_clk);
      chk(o_contact, e);
   endtask
   task t_idle;
      rdc(8'h10, 0);
      lo <= 8'h5a;
      cc(8'h5a);
      lo <= 0;
      rdc(8'h18, 0);
      $display("t_idle done");
   endtask
   task t_force;
      sel <= 4'he;
      wb(1, 8'h04, 32'hff);
      sel <= 4'hf;
      rdc(8'h04, 0);
      wb(1, 8'h04, 1);
      wb(1, 8'h08, 1);
      wb(1, 8'h00, 32'h6);
      cc(8'h01);
      rdc(8'h14, 8'h01);
      rdc(8'h04, 1);
      rdc(8'h08, 1);
      wb(1, 8'h08, 0);
      wb(1, 8'h00, 32'h10e);
      cc(8'h00);
      rdc(8'h00, 32'h100);
      wb(1, 8'h08, 1);
      wb(1, 8'h00, 32'h48);
      cc(8'h01);
      wb(1, 8'h00, 32'h40);
      cc(8'h00);
      $display("t_force done");
   endtask
   task t_timed;
      wb(1, 8'h04, 2);
      wb(1, 8'h08, 2);
      wb(1, 8'h00, 32'h2);
      cc(8'h02);
      repeat (10) @(posedge i_clk);
      cc(8'h02);
      repeat (5) @(posedge i_clk);
      cc(8'h00);
      $display("t_timed done");
   endtask
   task t_disarm;
      lo <= 8'hf0;
      la <= 8'h10;
      wb(1, 8'h0c, 2);
      rdc(8'h0c, 2);
      wb(1, 8'h00, 32'h1);
      rdc(8'h10, 0);
      wb(1, 8'h00, 32'h31);
      rdc(8'h10, 8'h60);
      lo <= 0;
      cc(8'h60);
      wb(1, 8'h04, 8'h20);
      wb(1, 8'h08, 0);
      wb(1, 8'h00, 32'h27);
      cc(8'h60);
      wb(1, 8'h00, 32'ha1);
      rdc(8'h10, 0);
      wb(1, 8'h00, 32'h41);
      la <= 0;
      $display("t_disarm done");
   endtask
   task t_hold;
      ho <= 8'h01;
      wb(1, 8'h0c, 1);
      wb(1, 8'h00, 32'h10);
      rdc(8'h10, 0);
      wb(1, 8'h00, 32'h11);
      rdc(8'h10, 8'h0e);
      ho <= 0;
      repeat (2) @(posedge i_clk);
      rdc(8'h10, 8'h0f);
      repeat (25) @(posedge i_clk);
      rdc(8'h10, 0);
      $display("t_hold done");
   endtask
   task t_reset;
      wb(1, 8'h04, 1);
      wb(1, 8'h08, 1);
      wb(1, 8'h00, 32'h6);
      cc(8'h01);
      i_rst <= 1;
      repeat (2) @(posedge i_clk);
      i_rst <= 0;
      cc(8'h00);
      rdc(8'h08, 0);
      $display("t_reset done");
   endtask
   task t_freeze;
      i_ce <= 0;
      lo <= 8'hff;
      cc(8'h00);
      i_ce <= 1;
      $display("t_freeze done");
   endtask
   task stop_test;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (2000) @(posedge i_clk);
      n_fail++;
      stop_test;
   end
   initial
   begin
      repeat (6) @(posedge i_clk);
      i_rst <= 0;
      t_idle;
      t_force;
      t_timed;
      t_disarm;
      t_hold;
      t_reset;
      t_freeze;
      stop_test;
   end
endmodule
`default_nettype wire
